// ==== design/sprot_top.sv ====
`timescale 1ns/100ps
`include "sprot_cfg.svh"
module sprot_top #(
  parameter logic [31:0] LAST_LBA = `SP_LAST_LBA
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire sprot_pkg::sprot_cmd_type  cmd,
  output logic                           done,
  output sprot_pkg::sprot_sts_type       status,
  output logic                           info_valid,
  output sprot_pkg::sprot_info_type      info,
  output sprot_pkg::sprot_chk_type       chk,
  input  wire sprot_pkg::sprot_byte_type host_rx,
  output logic                           host_rx_ready,
  output sprot_pkg::sprot_byte_type      host_tx,
  input  wire logic                      host_tx_ready,
  input  wire sprot_pkg::sprot_byte_type med_rx,
  output logic                           med_rx_ready,
  output sprot_pkg::sprot_byte_type      med_tx,
  input  wire logic                      med_tx_ready,
  output logic [12:0]                    med_sector_len,
  output logic                           fmt_req,
  input  wire logic                      fmt_done
);
  import sprot_pkg::*;

  // ****************************************
  // stream steering
  // ****************************************
  sprot_state_type s_ff;
  sprot_state_type nxt_s;
  logic            xfer;
  logic            in_pi;
  logic            last;
  logic            gen_byte;
  logic            drop;
  logic            slot_free;
  logic            src_valid;
  logic [7:0]      src_data;
  logic            dst_ready;
  logic            take;
  logic            emit;
  logic            step;
  logic            popped;
  logic [1:0]      fmtpinfo;
  logic [2:0]      prot;
  logic            is_rw;
  sprot_sts_type   rw_sts;
  sprot_sts_type   fmt_sts;
  sprot_pt_type    fmt_pt;
  logic [12:0]     fmt_sec;

  assign xfer      = ce && (s_ff.st == S_XFER);
  // the bytes past the data part of a sector are the protection bytes
  assign in_pi     = (s_ff.ptype != PT0) && (s_ff.idx >= s_ff.blen);
  // sec_len is zero only after a protected format with block length 13'h1ff8, where the sum wraps; a zero block length is refused at format
  assign last      = s_ff.idx == (s_ff.sec_len - 13'h001);
  // type 1 with a zero protect field behaves the same way: the media keeps
  // the protection bytes and the host never sees them
  assign gen_byte  = !s_ff.is_rd && in_pi && !s_ff.xfer_pi;
  assign drop      = s_ff.is_rd && in_pi && !s_ff.xfer_pi;
  assign dst_ready = s_ff.is_rd ? host_tx_ready : med_tx_ready;
  assign slot_free = !s_ff.ov || dst_ready;
  assign src_valid = s_ff.is_rd ? med_rx.valid : host_rx.valid;
  assign src_data  = s_ff.is_rd ? med_rx.data : host_rx.data;
  // a dropped byte needs no output slot, so it never waits on the host
  assign take      = xfer && !gen_byte && src_valid
                     && (drop || slot_free);
  assign emit      = xfer && slot_free
                     && (gen_byte || (src_valid && !drop));
  assign step      = gen_byte ? emit : take;
  assign popped    = ce && s_ff.ov && dst_ready;

  assign host_rx_ready = xfer && !s_ff.is_rd && !gen_byte && slot_free;
  assign med_rx_ready  = xfer && s_ff.is_rd && (drop || slot_free);
  // no new command while a byte still waits in the output slot
  assign cmd_ready     = ce && (s_ff.st == S_IDLE) && !s_ff.ov;

  assign fmtpinfo = cmd.fmt_byte1[`SP_FMT_MSB:`SP_FMT_LSB];
  assign is_rw    = (cmd.op == OP_READ) || (cmd.op == OP_WRITE);
  assign prot     = (cmd.op == OP_READ) ? cmd.read_check_select
                                        : cmd.write_check_select;

  // ****************************************
  // command decode
  // ****************************************
  // a refused command moves no data, so its verdict is settled up front
  always_comb begin
    rw_sts = ST_GOOD;
    // the long form is only legal where its extra tag fields mean something
    if (cmd.cdb_len == CDB32) begin
      if (s_ff.ptype != PT2) begin
        rw_sts = ST_BAD_LEN;
      end
    end else if (cmd.cdb_len != CDB10
                 && cmd.cdb_len != CDB16) begin
      rw_sts = ST_BAD_LEN;
    end else if (prot != `SP_CHK_OFF
                 && s_ff.ptype != PT1) begin
      rw_sts = ST_BAD_PROT;
    end
  end

  // the new type only takes effect once the media side reports the erase
  always_comb begin
    fmt_sts = ST_GOOD;
    fmt_pt  = PT0;
    // type 3 and the reserved code are both refused here
    // any nonzero block length is taken as given
    if (cmd.new_blen == 13'h000) begin
      fmt_sts = ST_BAD_FMT;
    end else if (fmtpinfo == `SP_FMT_T0) begin
      fmt_pt = PT0;
    end else if (fmtpinfo == `SP_FMT_T1) begin
      fmt_pt = PT1;
    end else if (fmtpinfo == `SP_FMT_T2
                 && cmd.fmt_usage == `SP_USE_T2) begin
      fmt_pt = PT2;
    end else begin
      fmt_sts = ST_BAD_FMT;
    end
  end

  // a protected sector carries the data part plus the protection bytes
  assign fmt_sec = (fmtpinfo == `SP_FMT_T0)
                   ? cmd.new_blen
                   : cmd.new_blen + `SP_PI_BYTES;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s            = s_ff;
    nxt_s.done       = 1'b0;
    nxt_s.info_valid = 1'b0;
    if (popped) begin
      nxt_s.ov = 1'b0;
    end
    if (emit) begin
      nxt_s.ov = 1'b1;
      nxt_s.od = gen_byte ? `SP_PI_FILL : src_data;
    end
    unique case (s_ff.st)
      S_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          nxt_s.done = 1'b1;
          nxt_s.sts  = ST_GOOD;
          unique case (cmd.op)
            OP_READ, OP_WRITE: begin
              nxt_s.is_rd = cmd.op == OP_READ;
              nxt_s.sts   = rw_sts;
            end
            OP_FORMAT: begin
              nxt_s.sts      = fmt_sts;
              nxt_s.new_pt   = fmt_pt;
              nxt_s.fmt_blen = cmd.new_blen;
              nxt_s.fmt_sec  = fmt_sec;
            end
            OP_INQ: begin
              nxt_s.info_valid    = 1'b1;
              nxt_s.info.prot_cap = 1'b1;
            end
            OP_VPD: begin
              if (cmd.page != `SP_VPD_PI) begin
                nxt_s.sts = ST_BAD_OP;
              end else begin
                nxt_s.info_valid   = 1'b1;
                nxt_s.info.sup_t1  = 1'b1;
                nxt_s.info.sup_t2  = 1'b1;
                nxt_s.info.sup_t3  = 1'b0;
                nxt_s.info.chk_grd = 1'b1;
                nxt_s.info.chk_app = 1'b1;
                nxt_s.info.chk_ref = 1'b1;
              end
            end
            OP_RCAP16: begin
              nxt_s.info_valid    = 1'b1;
              nxt_s.info.prot_en  = s_ff.ptype != PT0;
              nxt_s.info.p_type   = (s_ff.ptype == PT2)
                                    ? `SP_PTYPE_T2
                                    : `SP_PTYPE_T1;
              nxt_s.info.blen     = s_ff.blen;
              // capacity is the same whatever the format type
              nxt_s.info.last_lba = LAST_LBA;
            end
            default: begin
              nxt_s.sts = ST_BAD_OP;
            end
          endcase
          // a refused command moves no data and finishes at once
          if (nxt_s.sts == ST_GOOD && cmd.op == OP_FORMAT) begin
            nxt_s.done    = 1'b0;
            nxt_s.fmt_req = 1'b1;
            nxt_s.st      = S_FMT;
          end
          if (nxt_s.sts == ST_GOOD && is_rw
              && cmd.blocks != 16'h0000) begin
            nxt_s.done     = 1'b0;
            nxt_s.st       = S_XFER;
            nxt_s.idx      = 13'h000;
            nxt_s.blk_left = cmd.blocks;
            nxt_s.xfer_pi  = (s_ff.ptype != PT0)
                             && (prot != `SP_CHK_OFF);
            nxt_s.chk.active = nxt_s.xfer_pi;
            nxt_s.chk.sel    = prot;
            nxt_s.chk.exp_ref = cmd.exp_ref_tag;
            // the extra expected tags only exist in the long form
            nxt_s.chk.from_cdb32 = cmd.cdb_len == CDB32;
            nxt_s.chk.exp_app  = (cmd.cdb_len == CDB32)
                                 ? cmd.exp_app_tag : 16'h0000;
            nxt_s.chk.app_mask = (cmd.cdb_len == CDB32)
                                 ? cmd.app_tag_mask : 16'h0000;
          end
        end
      end
      S_XFER: begin
        // done may rise while the last byte still waits in the output slot
        if (step) begin
          if (last) begin
            nxt_s.idx      = 13'h000;
            nxt_s.blk_left = s_ff.blk_left - 16'h0001;
            if (s_ff.blk_left == 16'h0001) begin
              nxt_s.st         = S_IDLE;
              nxt_s.done       = 1'b1;
              nxt_s.sts        = ST_GOOD;
              nxt_s.chk.active = 1'b0;
            end
          end else begin
            nxt_s.idx = s_ff.idx + 13'h001;
          end
        end
      end
      S_FMT: begin
        // the media side erases every sector before fmt_done
        if (ce && fmt_done) begin
          nxt_s.fmt_req = 1'b0;
          nxt_s.ptype   = s_ff.new_pt;
          nxt_s.blen    = s_ff.fmt_blen;
          nxt_s.sec_len = s_ff.fmt_sec;
          nxt_s.done    = 1'b1;
          nxt_s.st      = S_IDLE;
        end
      end
      default: begin
        nxt_s.st = S_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  // ce low holds every field, so a stalled transfer resumes where it stopped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // a fresh device comes up as 512-byte blocks without protection
      s_ff         <= '0;
      s_ff.blen    <= `SP_BLEN_DEF;
      s_ff.sec_len <= `SP_BLEN_DEF;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign done           = s_ff.done;
  assign status         = s_ff.sts;
  assign info_valid     = s_ff.info_valid;
  assign info           = s_ff.info;
  assign chk            = s_ff.chk;
  assign fmt_req        = s_ff.fmt_req;
  // one output slot serves both directions, steered by the transfer's way
  assign host_tx.valid  = s_ff.ov && s_ff.is_rd;
  assign host_tx.data   = s_ff.od;
  assign med_tx.valid   = s_ff.ov && !s_ff.is_rd;
  assign med_tx.data    = s_ff.od;
  // during a format the media side sees the sector size being laid down
  assign med_sector_len = (s_ff.st == S_FMT) ? s_ff.fmt_sec
                                             : s_ff.sec_len;
endmodule

// ==== design/sprot_cfg.svh ====
`ifndef SPROT_CFG_SVH
`define SPROT_CFG_SVH
// ****************************************
// constants
// ****************************************
`define SP_BLEN_DEF   13'h200
`define SP_PI_BYTES   13'h008
`define SP_PI_FILL    8'hff
`define SP_FMT_T0     2'h0
`define SP_FMT_T1     2'h2
`define SP_FMT_T2     2'h3
`define SP_FMT_MSB    7
`define SP_FMT_LSB    6
`define SP_USE_T2     3'h0
`define SP_VPD_PI     8'h86
`define SP_PTYPE_T1   3'h0
`define SP_PTYPE_T2   3'h1
`define SP_CHK_OFF    3'h0
`define SP_LAST_LBA   32'h0010_0000
`endif

// ==== design/sprot_pkg.sv ====
package sprot_pkg;
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_WRITE  = 3'h1,
    OP_FORMAT = 3'h2,
    OP_INQ    = 3'h3,
    OP_VPD    = 3'h4,
    OP_RCAP16 = 3'h5
  } sprot_op_type;
  typedef enum logic [1:0] {
    CDB10 = 2'h0,
    CDB16 = 2'h1,
    CDB32 = 2'h2
  } sprot_len_type;
  typedef enum logic [1:0] {
    PT0 = 2'h0,
    PT1 = 2'h1,
    PT2 = 2'h2
  } sprot_pt_type;
  typedef enum logic [2:0] {
    ST_GOOD     = 3'h0,
    ST_BAD_LEN  = 3'h1,
    ST_BAD_PROT = 3'h2,
    ST_BAD_FMT  = 3'h3,
    ST_BAD_OP   = 3'h4
  } sprot_sts_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_XFER = 2'h1,
    S_FMT  = 2'h2
  } sprot_fsm_type;
  typedef struct packed {
    sprot_op_type  op;
    sprot_len_type cdb_len;
    logic [2:0]    read_check_select;
    logic [2:0]    write_check_select;
    logic [15:0]   blocks;
    logic [7:0]    fmt_byte1;
    logic [2:0]    fmt_usage;
    logic [12:0]   new_blen;
    logic [7:0]    page;
    logic [31:0]   exp_ref_tag;
    logic [15:0]   exp_app_tag;
    logic [15:0]   app_tag_mask;
  } sprot_cmd_type;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sprot_byte_type;
  typedef struct packed {
    logic        prot_cap;
    logic        sup_t1;
    logic        sup_t2;
    logic        sup_t3;
    logic        chk_grd;
    logic        chk_app;
    logic        chk_ref;
    logic        prot_en;
    logic [2:0]  p_type;
    logic [12:0] blen;
    logic [31:0] last_lba;
  } sprot_info_type;
  typedef struct packed {
    logic        active;
    logic [2:0]  sel;
    logic        from_cdb32;
    logic [31:0] exp_ref;
    logic [15:0] exp_app;
    logic [15:0] app_mask;
  } sprot_chk_type;
  typedef struct packed {
    sprot_fsm_type  st;
    sprot_pt_type   ptype;
    sprot_pt_type   new_pt;
    logic [12:0]    blen;
    logic [12:0]    sec_len;
    logic [12:0]    fmt_blen;
    logic [12:0]    fmt_sec;
    logic [12:0]    idx;
    logic [15:0]    blk_left;
    logic           is_rd;
    logic           xfer_pi;
    logic           ov;
    logic [7:0]     od;
    logic           done;
    sprot_sts_type  sts;
    logic           fmt_req;
    logic           info_valid;
    sprot_info_type info;
    sprot_chk_type  chk;
  } sprot_state_type;
endpackage

// ==== tb/sprot_top_checker.sv ====
`timescale 1ns/100ps
module sprot_top_checker #(
  parameter logic [31:0] LAST_LBA = 32'h0010_0000
) (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      ce,
  input wire logic                      cmd_valid,
  input wire logic                      cmd_ready,
  input wire sprot_pkg::sprot_cmd_type  cmd,
  input wire logic                      done,
  input wire sprot_pkg::sprot_sts_type  status,
  input wire logic                      info_valid,
  input wire sprot_pkg::sprot_info_type info,
  input wire logic                      med_rx_ready,
  input wire logic [12:0]               med_sector_len,
  input wire logic                      fmt_req,
  input wire logic                      fmt_done
);
  import sprot_pkg::*;
  logic        take;
  logic        rw;
  logic [12:0] exp_len_ff;
  assign take = cmd_valid && cmd_ready;
  assign rw = cmd.op == OP_READ || cmd.op == OP_WRITE;
  // ****************************************
  // sector length a format should leave behind
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exp_len_ff <= 13'h200;
    end else if (take && cmd.op == OP_FORMAT) begin
      exp_len_ff <= cmd.new_blen + (cmd.fmt_byte1[7] ? 13'h008 : 13'h000);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_len: assert property (
    $fell(rst) |-> med_sector_len == 13'h200
  ) else $error("sector length not 512 after reset");
  a_bad_len: assert property (
    take && rw && cmd.cdb_len == 2'h3 |=> done && status == ST_BAD_LEN
  ) else $error("bad length not refused");
  a_bad_page: assert property (
    take && cmd.op == OP_VPD && cmd.page != 8'h86 |=> status == ST_BAD_OP
  ) else $error("unknown page not refused");
  a_fmt_start: assert property (
    take && cmd.op == OP_FORMAT && cmd.fmt_byte1 == 8'h90
    && cmd.new_blen != 13'h000 |=> fmt_req && !done
  ) else $error("format did not start");
  a_fmt_hold: assert property (
    fmt_req && !fmt_done |=> fmt_req && !med_rx_ready
  ) else $error("format ended without media answer");
  a_fmt_len: assert property (
    fmt_req && fmt_done && ce |=> done && med_sector_len == exp_len_ff
  ) else $error("sector length wrong after format");
  a_inq_caps: assert property (
    take && cmd.op == OP_INQ |=> info_valid && info.prot_cap && !info.sup_t3
  ) else $error("inquiry support bits wrong");
  a_rcap_lba: assert property (
    take && cmd.op == OP_RCAP16 |=> info_valid && info.last_lba == LAST_LBA
  ) else $error("capacity depends on type");
endmodule
bind sprot_top sprot_top_checker #(.LAST_LBA(LAST_LBA)) sprot_top_checker_i (
  .mclk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd, .done, .status,
  .info_valid, .info, .med_rx_ready, .med_sector_len, .fmt_req, .fmt_done);

// ==== tb/sprot_host_model.sv ====
`timescale 1ns/100ps
module sprot_host_model (
  input  wire logic                      mclk,
  input  wire logic                      slow,
  input  wire logic                      host_rx_ready,
  input  wire sprot_pkg::sprot_byte_type host_tx,
  output sprot_pkg::sprot_byte_type      host_rx,
  output logic                           host_tx_ready,
  output int                             n_in,
  output int                             n_out
);
  import sprot_pkg::*;
  logic rx_hs;
  initial begin
    host_rx = '{valid: 1'b1, data: 8'h00};
    host_tx_ready = 1'b0;
    n_in = 0;
    n_out = 0;
    rx_hs = 1'b0;
  end
  // ****************************************
  // count at the quiet edge, advance at the active one
  // ****************************************
  always @(negedge mclk) begin
    rx_hs = host_rx.valid && host_rx_ready;
    n_out += rx_hs;
    n_in += host_tx.valid && host_tx_ready;
  end
  // a slow host stalls every other cycle to exercise the output slot
  always @(posedge mclk) begin
    host_tx_ready <= slow ? !host_tx_ready : 1'b1;
    if (rx_hs) begin
      host_rx.data <= host_rx.data + 8'h01;
    end
  end
endmodule

// ==== tb/sprot_top_test.sv ====
`timescale 1ns/100ps
`define CHK(s, e, a) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", s, e, a); \
  end \
end
module sprot_top_test;
  import sprot_pkg::*;
  localparam logic [31:0] LBA_N = 32'h0000_0123;
  logic           mclk, rst, ce, cmd_valid, cmd_ready, done, info_valid;
  logic           fmt_req, fmt_done, slow, host_rx_ready, host_tx_ready;
  logic           med_rx_ready, med_tx_ready, med_hs;
  logic [12:0]    med_sector_len;
  logic [63:0]    last8;
  sprot_cmd_type  cmd, c;
  sprot_sts_type  status;
  sprot_info_type info;
  sprot_chk_type  chk;
  sprot_byte_type host_rx, host_tx, med_rx, med_tx;
  int             miscompares, checks_done, n_in, n_out, n_med;
  sprot_top #(.LAST_LBA(LBA_N)) sprot_top_i (
    .mclk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd, .done, .status,
    .info_valid, .info, .chk, .host_rx, .host_rx_ready, .host_tx,
    .host_tx_ready, .med_rx, .med_rx_ready, .med_tx, .med_tx_ready,
    .med_sector_len, .fmt_req, .fmt_done);
  sprot_host_model sprot_host_model_i (
    .mclk, .slow, .host_rx_ready, .host_tx, .host_rx, .host_tx_ready,
    .n_in, .n_out);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    med_hs = med_rx.valid && med_rx_ready;
    if (med_tx.valid && med_tx_ready) begin
      n_med++;
      last8 = {last8[55:0], med_tx.data};
    end
  end
  always @(posedge mclk) begin
    if (med_hs) med_rx.data <= med_rx.data + 8'h01;
    med_tx_ready <= slow ? !med_tx_ready : 1'b1;
    fmt_done <= fmt_req && !fmt_done;
  end
  // ****************************************
  // tasks
  // ****************************************
  function automatic sprot_cmd_type mk(sprot_op_type o, sprot_len_type l,
                                       logic [2:0] r, logic [2:0] w);
    mk = '0;
    mk.op = o;
    mk.cdb_len = l;
    mk.read_check_select = r;
    mk.write_check_select = w;
    mk.blocks = 16'h0001;
  endfunction
  task run(input sprot_cmd_type k, input sprot_sts_type e, input int hb, mb);
    int n, h0, m0;
    h0 = n_in + n_out;
    m0 = n_med;
    cmd <= k;
    cmd_valid <= 1'b1;
    n = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    `CHK("command ready", 1'b1, cmd_ready)
    @(posedge mclk);
    cmd_valid <= 1'b0;
    n = 0;
    @(negedge mclk);
    while (done !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("status", e, status)
    repeat (4) @(negedge mclk);
    `CHK("host bytes", hb, n_in + n_out - h0)
    if (mb >= 0) `CHK("media bytes", mb, n_med - m0)
    @(posedge mclk);
  endtask
  task fmt(input logic [7:0] b, input logic [2:0] u, input logic [12:0] n,
           input sprot_sts_type e, input logic [12:0] len);
    c = mk(OP_FORMAT, CDB10, 3'h0, 3'h0);
    c.fmt_byte1 = b;
    c.fmt_usage = u;
    c.new_blen = n;
    run(c, e, 0, -1);
    `CHK("sector length", len, med_sector_len)
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {rst, ce, cmd_valid, fmt_done, slow, med_tx_ready} = 6'h31;
    cmd = '0;
    med_rx = '{valid: 1'b1, data: 8'h00};
    {miscompares, checks_done, n_med, last8} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    run(mk(OP_READ, CDB10, 3'h0, 3'h0), ST_GOOD, 512, 0);
    run(mk(OP_WRITE, CDB10, 3'h0, 3'h0), ST_GOOD, 512, 512);
    run(mk(OP_READ, CDB10, 3'h1, 3'h0), ST_BAD_PROT, 0, 0);
    run(mk(OP_READ, CDB32, 3'h0, 3'h0), ST_BAD_LEN, 0, 0);
    c = mk(OP_WRITE, sprot_len_type'(2'h3), 3'h0, 3'h0);
    run(c, ST_BAD_LEN, 0, 0);
    run(mk(sprot_op_type'(3'h7), CDB10, 3'h0, 3'h0), ST_BAD_OP, 0, 0);
    c = mk(OP_READ, CDB10, 3'h0, 3'h0);
    c.blocks = 16'h0000;
    run(c, ST_GOOD, 0, 0);
    run(mk(OP_INQ, CDB10, 3'h0, 3'h0), ST_GOOD, 0, 0);
    `CHK("inquiry bit", 1'b1, info.prot_cap)
    c = mk(OP_VPD, CDB10, 3'h0, 3'h0);
    c.page = 8'h80;
    run(c, ST_BAD_OP, 0, 0);
    c.page = 8'h86;
    run(c, ST_GOOD, 0, 0);
    `CHK("type 2 support", 1'b1, info.sup_t2)
    `CHK("page bits", 3'h7, {info.chk_grd, info.chk_app, info.chk_ref})
    $display("test type0 end");
    fmt(8'h50, 3'h0, 13'h200, ST_BAD_FMT, 13'h200);
    fmt(8'hc0, 3'h1, 13'h200, ST_BAD_FMT, 13'h200);
    fmt(8'h90, 3'h0, 13'h000, ST_BAD_FMT, 13'h200);
    fmt(8'h90, 3'h0, 13'h200, ST_GOOD, 13'h208);
    run(mk(OP_RCAP16, CDB16, 3'h0, 3'h0), ST_GOOD, 0, 0);
    `CHK("type code", 4'h8, {info.prot_en, info.p_type})
    `CHK("last block", LBA_N, info.last_lba)
    slow <= 1'b1;
    c = mk(OP_READ, CDB16, 3'h1, 3'h0);
    c.blocks = 16'h0002;
    run(c, ST_GOOD, 1040, 0);
    run(mk(OP_READ, CDB32, 3'h1, 3'h0), ST_BAD_LEN, 0, 0);
    run(mk(OP_WRITE, CDB10, 3'h0, 3'h2), ST_GOOD, 520, 520);
    slow <= 1'b0;
    $display("test type1 end");
    fmt(8'hd0, 3'h0, 13'h100, ST_GOOD, 13'h108);
    run(mk(OP_RCAP16, CDB16, 3'h0, 3'h0), ST_GOOD, 0, 0);
    `CHK("type code", 4'h9, {info.prot_en, info.p_type})
    run(mk(OP_READ, CDB10, 3'h1, 3'h0), ST_BAD_PROT, 0, 0);
    run(mk(OP_WRITE, CDB16, 3'h0, 3'h0), ST_GOOD, 256, 264);
    `CHK("fill bytes", 64'hffff_ffff_ffff_ffff, last8)
    run(mk(OP_READ, CDB16, 3'h0, 3'h0), ST_GOOD, 256, 0);
    c = mk(OP_READ, CDB32, 3'h1, 3'h0);
    c.exp_app_tag = 16'h5a5a;
    run(c, ST_GOOD, 264, 0);
    `CHK("app tag", 17'h15a5a, {chk.from_cdb32, chk.exp_app})
    `CHK("check select", 4'h1, {chk.active, chk.sel})
    $display("test type2 end");
    ce <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("frozen ready", 1'b0, cmd_ready)
    @(posedge mclk);
    ce <= 1'b1;
    fmt(8'h00, 3'h0, 13'h200, ST_GOOD, 13'h200);
    run(mk(OP_RCAP16, CDB16, 3'h0, 3'h0), ST_GOOD, 0, 0);
    `CHK("protection off", 1'b0, info.prot_en)
    $display("test reformat end");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done;
  end
endmodule
